// file: hdl/tra_pkg.sv
// Shared map, config fields and crossing records of the sensor block
`default_nettype none
package tra_pkg;
  // ----------------------------------------------------------------
  // Register pointer values and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0]  PTR_TEMP  = 2'h0;
  localparam logic [1:0]  PTR_CFG   = 2'h1;
  localparam logic [1:0]  PTR_TLOW  = 2'h2;
  localparam logic [1:0]  PTR_THIGH = 2'h3;
  localparam logic [15:0] TEMP_RST  = 16'h0000;
  localparam logic [15:0] CFG_RST   = 16'h0000;
  localparam logic [15:0] TLOW_RST  = 16'h4b00;
  localparam logic [15:0] THIGH_RST = 16'h5000;
  localparam logic [3:0]  TEMP_PAD  = 4'h0;   // Unused low bits
  // ----------------------------------------------------------------
  // Config fields, all in the most significant byte
  // ----------------------------------------------------------------
  localparam int CFG_SHDN  = 8;
  localparam int CFG_MODE  = 9;
  localparam int CFG_ALERT_POLARITY  = 10;
  localparam int CFG_FAULT_QUEUE_LEN = 11;   // Low bit of the field
  // ----------------------------------------------------------------
  // Bus bytes and link constants
  // ----------------------------------------------------------------
  localparam logic [6:0] DEV_ADDR_DFLT = 7'h48;
  localparam logic [7:0] ALERT_CMD     = 8'h19;
  localparam logic [7:0] GC_ADDR       = 8'h00;
  localparam logic [7:0] GC_RESET      = 8'h06;
  localparam logic [3:0] BITS_BYTE     = 4'h8;
  localparam logic [1:0] IDX_PTR       = 2'h0;
  localparam logic [1:0] IDX_LSB       = 2'h2;

  typedef enum logic [1:0] {
    EV_WRITE      = 2'b00,
    EV_READ       = 2'b01,
    EV_ALERT_DONE = 2'b10,
    EV_GC_RESET   = 2'b11
  } tra_ev_kind_type;

  // Event from bus logic to register logic
  typedef struct packed {
    tra_ev_kind_type kind;
    logic [1:0]      ptr;
    logic            lsb;
    logic [7:0]      data;
  } tra_event_type;

  // Register image handed to the bus logic
  typedef struct packed {
    logic [15:0] temp;
    logic [15:0] cfg;
    logic [15:0] tlow;
    logic [15:0] thigh;
    logic        act;
    logic        hi;
  } tra_snap_type;

  // Consecutive fault count per queue code
  function automatic logic [2:0] tra_run_count(input logic [1:0] code);
    case (code)
      2'h0:    tra_run_count = 3'h1;
      2'h1:    tra_run_count = 3'h2;
      2'h2:    tra_run_count = 3'h4;
      default: tra_run_count = 3'h6;
    endcase
  endfunction

  // Signed compare of left-justified codes
  function automatic logic tra_sge(input logic [15:0] a,
                                   input logic [15:0] b);
    tra_sge = $signed(a) >= $signed(b);
  endfunction
endpackage
`default_nettype wire

// file: hdl/tra_sensor.sv
// Temperature result, limit alert and two-wire slave of the sensor
`default_nettype none
// Function
// - Each conversion's 12-bit result lands in a read-only result register.
// - Result is read as two bytes, high byte first; one byte suffices.
// - Result left-justified in sixteen bits, low four bits unused.
// - One code step equals one sixteenth degree Celsius.
// - Negative temperatures are twos complement, top bit is sign.
// - Limits share the result format; both compared each conversion.
// - Alert mode bit picks comparator or latched interrupt behaviour.
// - Comparator mode: assert after queued runs at or above upper limit.
// - Comparator mode: release after queued runs below lower limit.
// - Interrupt mode: assert after queued runs at or above upper limit.
// - Interrupt alert holds until any read or won alert response.
// - Entering shutdown clears the alert.
// - Interrupt mode alternates watching upper then lower limit.
// - General-call reset clears alert, registers, counter, forces comparator.
// - Polarity bit: zero gives active low alert, one active high.
// - Slave only, open-drain data, never drives the clock.
// - Bus runs up to 400 kHz fast and 3 MHz high speed.
// - Bytes shift most significant bit first both ways.
// - Address last bit is direction; acknowledge low on ninth pulse.
// - Eight data pulses then acknowledge; data steady while clock high.
// - Alert command answered with own address, last bit marks fault side.
// - Alert released only when address arbitration is won.
// - First written byte loads pointer, kept for later reads.
module tra_sensor
  import tra_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DFLT
) (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [11:0] temp_code_in,
  input  wire logic        conv_done_in,
  input  wire logic        link_clk_in,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_out,
  output logic             alert_out
);
  // ----------------------------------------------------------------
  // Link domain: synchronisers and bus conditions
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_ADDR = 3'b001, ST_AACK = 3'b010,
    ST_RX   = 3'b011, ST_RACK = 3'b100, ST_TX   = 3'b101,
    ST_TACK = 3'b110
  } tra_st_type;

  logic [1:0]    lrst_s;
  logic [2:0]    scl_s, sda_s;
  tra_st_type    st_r, st_nxt;
  logic [7:0]    sh_r, sh_nxt;
  logic [3:0]    cnt_r, cnt_nxt;
  logic [1:0]    ptr_r, ptr_nxt, idx_r, idx_nxt;
  logic          rw_r, rw_nxt, gc_r, gc_nxt, alrt_r, alrt_nxt;
  logic          lsb_r, lsb_nxt, drv_r, drv_nxt;
  logic [15:0]   txw_r, txw_nxt;
  tra_event_type ev_r, ev_nxt;
  logic          ev_tgl_r, ev_go;
  tra_snap_type  snap_l_r, snap_r;
  logic [1:0]    req_s;
  logic          ack_l_r, req_tgl_r;

  // oversampling synchronisers; link clock must outpace the bus
  always_ff @(posedge link_clk_in) begin
    lrst_s <= {lrst_s[0], rst_n_in};
    scl_s  <= {scl_s[1:0], scl_in};
    sda_s  <= {sda_s[1:0], sda_in};
    req_s  <= {req_s[0], req_tgl_r};
  end

  wire lrst     = ~lrst_s[1];
  wire scl_rise = scl_s[1] & ~scl_s[2];
  wire scl_fall = ~scl_s[1] & scl_s[2];
  wire scl_hi   = scl_s[1] & scl_s[2];
  wire start_c  = scl_hi & ~sda_s[1] & sda_s[2];
  wire stop_c   = scl_hi & sda_s[1] & ~sda_s[2];
  wire sda_v    = sda_s[1];

  // Address byte decode
  wire m_dev   = sh_r[7:1] == DEV_ADDR;
  // alert command answered only while alert active
  wire m_alert = (sh_r == ALERT_CMD) & snap_l_r.act;
  wire m_gc    = sh_r == GC_ADDR;
  wire bdone   = cnt_r == BITS_BYTE;
  wire [7:0]  tx_byte = lsb_r ? txw_r[7:0] : txw_r[15:8];
  wire [2:0]  tx_idx  = 3'h7 - cnt_r[2:0];
  wire [15:0] sel_w   = (ptr_r == PTR_TEMP) ? snap_l_r.temp :
                        (ptr_r == PTR_CFG)  ? snap_l_r.cfg  :
                        (ptr_r == PTR_TLOW) ? snap_l_r.tlow :
                                              snap_l_r.thigh;

  // Next state of the byte engine
  always_comb begin
    st_nxt = st_r;  sh_nxt = sh_r;  cnt_nxt = cnt_r;
    ptr_nxt = ptr_r; idx_nxt = idx_r; rw_nxt = rw_r;
    gc_nxt = gc_r;  alrt_nxt = alrt_r; lsb_nxt = lsb_r;
    drv_nxt = drv_r; txw_nxt = txw_r; ev_nxt = ev_r; ev_go = 1'b0;
    // shift in MSB first on each rising clock
    if (scl_rise && st_r != ST_IDLE) begin
      sh_nxt  = {sh_r[6:0], sda_v};
      cnt_nxt = cnt_r + 4'h1;
    end
    unique case (st_r)
      ST_IDLE: ;
      ST_ADDR: if (scl_fall && bdone) begin
        if (m_dev | m_alert | m_gc) begin
          st_nxt = ST_AACK; drv_nxt = 1'b1; rw_nxt = sh_r[0];
          alrt_nxt = m_alert & ~m_dev; gc_nxt = m_gc;
          idx_nxt = IDX_PTR; lsb_nxt = 1'b0;
          txw_nxt = m_alert & ~m_dev ?
                    {DEV_ADDR, snap_l_r.hi, 8'h00} : sel_w;
          // any register read clears interrupt alert
          if (m_dev & sh_r[0]) begin
            ev_nxt = '{EV_READ, ptr_r, 1'b0, 8'h00}; ev_go = 1'b1;
          end
        end else st_nxt = ST_IDLE;
      end
      ST_AACK: if (scl_fall) begin
        cnt_nxt = '0;
        st_nxt  = rw_r ? ST_TX : ST_RX;
        drv_nxt = rw_r & ~tx_byte[7];
      end
      // high byte then low byte, MSB first
      ST_TX: begin
        // released one but line low: arbitration lost
        if (scl_rise && alrt_r && !drv_r && !sda_v) begin
          st_nxt = ST_IDLE; drv_nxt = 1'b0;
        end else if (scl_fall) begin
          if (bdone) begin
            st_nxt = ST_TACK; drv_nxt = 1'b0;
          end else drv_nxt = ~tx_byte[tx_idx];
        end
      end
      ST_TACK: if (scl_fall) begin
        cnt_nxt = '0;
        if (alrt_r) begin
          ev_nxt = '{EV_ALERT_DONE, ptr_r, 1'b0, 8'h00}; ev_go = 1'b1;
          st_nxt = ST_IDLE;
        end else if (sh_r[0]) st_nxt = ST_IDLE;
        else begin
          st_nxt  = ST_TX; lsb_nxt = ~lsb_r;
          drv_nxt = lsb_r ? ~txw_r[15] : ~txw_r[7];
        end
      end
      ST_RX: if (scl_fall && bdone) begin
        st_nxt = ST_RACK; drv_nxt = 1'b1;
        if (gc_r) begin
          if (sh_r == GC_RESET) begin
            ev_nxt = '{EV_GC_RESET, ptr_r, 1'b0, 8'h00}; ev_go = 1'b1;
          end
        end else if (idx_r == IDX_PTR) begin
          ptr_nxt = sh_r[1:0]; idx_nxt = idx_r + 2'h1;
        end else begin
          ev_nxt = '{EV_WRITE, ptr_r, idx_r == IDX_LSB, sh_r};
          ev_go  = 1'b1;
          if (idx_r != IDX_LSB) idx_nxt = idx_r + 2'h1;
        end
      end
      ST_RACK: if (scl_fall) begin
        st_nxt = ST_RX; cnt_nxt = '0; drv_nxt = 1'b0;
      end
      default: begin
        st_nxt = ST_IDLE; drv_nxt = 1'b0;
      end
    endcase
    if (stop_c) begin
      st_nxt = ST_IDLE; drv_nxt = 1'b0;
    end
    if (start_c) begin
      st_nxt = ST_ADDR; cnt_nxt = '0; drv_nxt = 1'b0;
    end
  end

  // Link registers
  always_ff @(posedge link_clk_in) begin
    if (lrst) begin
      st_r <= ST_IDLE; sh_r <= '0; cnt_r <= '0; ptr_r <= PTR_TEMP;
      idx_r <= IDX_PTR; rw_r <= 1'b0; gc_r <= 1'b0; alrt_r <= 1'b0;
      lsb_r <= 1'b0; drv_r <= 1'b0; txw_r <= '0; ev_r <= '0;
      ev_tgl_r <= 1'b0;
    end else begin
      st_r <= st_nxt; sh_r <= sh_nxt; cnt_r <= cnt_nxt;
      ptr_r <= ptr_nxt; idx_r <= idx_nxt; rw_r <= rw_nxt;
      gc_r <= gc_nxt; alrt_r <= alrt_nxt; lsb_r <= lsb_nxt;
      drv_r <= drv_nxt; txw_r <= txw_nxt; ev_r <= ev_nxt;
      ev_tgl_r <= ev_tgl_r ^ ev_go;
    end
  end

  // Snapshot capture; image held stable until acknowledged
  always_ff @(posedge link_clk_in) begin
    if (lrst) begin
      snap_l_r <= '0; ack_l_r <= 1'b0;
    end else if (req_s[1] != ack_l_r) begin
      snap_l_r <= snap_r; ack_l_r <= req_s[1];
    end
  end

  // open drain: only ever pulls data low, no clock drive
  assign sda_out    = 1'b0;
  assign sda_oe_out = drv_r;

  // ----------------------------------------------------------------
  // System domain: registers, limits and alert
  // ----------------------------------------------------------------
  logic [2:0]  ev_s;
  logic [1:0]  ack_s;
  logic [15:0] temp_r, temp_nxt, cfg_r, cfg_nxt;
  logic [15:0] tlow_r, tlow_nxt, thigh_r, thigh_nxt;
  logic [2:0]  fc_r, fc_nxt;
  logic        act_r, act_nxt, hi_r, hi_nxt, wh_r, wh_nxt;
  logic        alert_r;

  // Event toggle and snapshot acknowledge synchronisers
  always_ff @(posedge sys_clk_in) begin
    ev_s  <= {ev_s[1:0], ev_tgl_r};
    ack_s <= {ack_s[0], ack_l_r};
  end

  // Events are spaced by whole bytes, so ev_r is stable here
  wire ev_stb  = ev_s[1] ^ ev_s[2];
  wire gc_rst  = ev_stb & (ev_r.kind == EV_GC_RESET);
  wire wr      = ev_stb & (ev_r.kind == EV_WRITE);
  wire rd_clr  = ev_stb & (ev_r.kind == EV_READ);
  wire ad_clr  = ev_stb & (ev_r.kind == EV_ALERT_DONE);
  wire shdn    = cfg_r[CFG_SHDN];
  wire mode    = cfg_r[CFG_MODE];
  wire alert_polarity = cfg_r[CFG_ALERT_POLARITY];
  wire wr_cfg  = wr & (ev_r.ptr == PTR_CFG) & ~ev_r.lsb;
  wire shdn_in = wr_cfg & ev_r.data[CFG_SHDN-8] & ~shdn;
  wire conv    = conv_done_in & ~shdn;
  wire [15:0] t_new = {temp_code_in, TEMP_PAD};
  // both limits compared on every conversion
  wire hi_c    = tra_sge(t_new, thigh_r);
  wire lo_c    = ~tra_sge(t_new, tlow_r);
  // comparator watches by state, interrupt alternates
  wire watch   = mode ? wh_r : ~act_r;
  wire qual    = (watch ? hi_c : lo_c) & ~(mode & act_r);
  wire [2:0] fc_inc = fc_r + 3'h1;
  wire fire    = conv & qual &
                 (fc_inc >= tra_run_count(cfg_r[CFG_FAULT_QUEUE_LEN+:2]));

  // Register writes, merged per byte lane
  function automatic logic [15:0] lane(input logic [15:0] old,
                                       input logic [1:0] p);
    lane = old;
    if (wr && ev_r.ptr == p) begin
      if (ev_r.lsb) lane[7:0] = ev_r.data;
      else          lane[15:8] = ev_r.data;
    end
  endfunction

  always_comb begin
    // result register loads only from conversions and general-call reset
    temp_nxt  = conv ? t_new : temp_r;
    cfg_nxt   = lane(cfg_r, PTR_CFG);
    tlow_nxt  = lane(tlow_r, PTR_TLOW);
    thigh_nxt = lane(thigh_r, PTR_THIGH);
    // counter restarts on a non-qualifying conversion
    fc_nxt    = conv ? (qual ? fc_inc : 3'h0) : fc_r;
    act_nxt = act_r; hi_nxt = hi_r; wh_nxt = wh_r;
    // read or won alert response clears interrupt alert
    if (mode && (rd_clr || ad_clr)) act_nxt = 1'b0;
    if (shdn_in) act_nxt = 1'b0;
    if (fire) begin
      fc_nxt = 3'h0;
      if (mode) begin
        // latch then watch the other limit
        act_nxt = 1'b1; hi_nxt = wh_r; wh_nxt = ~wh_r;
      end else begin
        act_nxt = watch; hi_nxt = watch;
      end
    end
    if (gc_rst) begin
      temp_nxt = TEMP_RST; cfg_nxt = CFG_RST; tlow_nxt = TLOW_RST;
      thigh_nxt = THIGH_RST; fc_nxt = 3'h0; act_nxt = 1'b0;
      hi_nxt = 1'b0; wh_nxt = 1'b1;
    end
  end

  // System registers and snapshot request
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      temp_r <= TEMP_RST; cfg_r <= CFG_RST; tlow_r <= TLOW_RST;
      thigh_r <= THIGH_RST; fc_r <= 3'h0; act_r <= 1'b0;
      hi_r <= 1'b0; wh_r <= 1'b1; alert_r <= 1'b1;
      snap_r <= '0; req_tgl_r <= 1'b0;
    end else begin
      temp_r <= temp_nxt; cfg_r <= cfg_nxt; tlow_r <= tlow_nxt;
      thigh_r <= thigh_nxt; fc_r <= fc_nxt; act_r <= act_nxt;
      hi_r <= hi_nxt; wh_r <= wh_nxt;
      alert_r <= ~(act_r ^ alert_polarity);
      if (req_tgl_r == ack_s[1]) begin
        snap_r <= '{temp_r, cfg_r, tlow_r, thigh_r, act_r, hi_r};
        req_tgl_r <= ~req_tgl_r;
      end
    end
  end

  assign alert_out = alert_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  AST_TEMP_LOAD: assert property (
    conv && !gc_rst |=> temp_r == {$past(temp_code_in), TEMP_PAD})
    else $error("result not loaded left-justified");
  AST_TEMP_RO: assert property (
    wr && ev_r.ptr == PTR_TEMP && !conv_done_in && !gc_rst
    |=> $stable(temp_r)) else $error("result register written");
  AST_CMP_SET: assert property (
    !mode && !act_r && fire && !gc_rst |=> act_r ##1 alert_r == alert_polarity)
    else $error("comparator alert did not assert");
  AST_CMP_HOLD: assert property (
    !mode && act_r && !fire && !gc_rst && !shdn_in |=> act_r)
    else $error("comparator alert dropped early");
  AST_INT_CLR: assert property (
    mode && act_r && (rd_clr || ad_clr) && !fire |=> !act_r)
    else $error("interrupt alert not cleared");
  AST_SHDN: assert property (
    shdn_in && !fire |=> !act_r) else $error("shutdown kept alert");
  AST_GC: assert property (
    gc_rst |=> !act_r && cfg_r == CFG_RST && fc_r == 3'h0 && !mode)
    else $error("general-call reset incomplete");
  AST_POLARITY: assert property (
    $stable(act_r) && $stable(alert_polarity)
    |-> alert_r == ~(act_r ^ alert_polarity))
    else $error("alert level wrong for polarity");
  AST_INT_ALT: assert property (
    mode && fire && !gc_rst |=> wh_r == !$past(wh_r) && act_r)
    else $error("interrupt limit did not alternate");
  AST_RUN_RST: assert property (
    conv && !qual && !gc_rst |=> fc_r == 3'h0)
    else $error("fault counter not restarted");
  AST_ACK: assert property (@(posedge link_clk_in) disable iff (lrst)
    st_r == ST_AACK |-> sda_oe_out)
    else $error("address not acknowledged");

  COV_CMP: cover property (!mode && fire && !act_r);
  COV_INT_RD: cover property (mode && act_r && rd_clr);
  COV_ALERT_RESP: cover property (ad_clr && act_r);
  COV_GC: cover property (gc_rst);
endmodule // tra_sensor
`default_nettype wire

// file: testbench/tra_bus_master.sv
// Two-wire bus master model that drives clock and open-drain data
`default_nettype none
module tra_bus_master (
  input  wire logic link_clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // high phase in link clocks keeps the bus under 3 MHz
  localparam int HALF = 12;

  // Idle bus: both lines released high
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end

  // Wait link clock edges; all line changes land just after an edge
  task automatic tick(input int n);
    repeat (n) @(posedge link_clk_in);
  endtask

  // start framing, also usable as repeated start
  task automatic start();
    tick(2);
    sda_out <= 1'b1;
    tick(HALF);
    scl_out <= 1'b1;
    tick(HALF);
    sda_out <= 1'b0;
    tick(HALF);
    scl_out <= 1'b0;
  endtask

  // stop framing after the final transfer
  task automatic stop();
    tick(2);
    sda_out <= 1'b0;
    tick(HALF);
    scl_out <= 1'b1;
    tick(HALF);
    sda_out <= 1'b1;
    tick(HALF);
  endtask

  // data changes only while the clock is low
  task automatic bit_io(input logic b, output logic r);
    tick(2);
    sda_out <= b;
    tick(HALF);
    scl_out <= 1'b1;
    tick(HALF);
    r = sda_in;
    scl_out <= 1'b0;
  endtask

  // eight bits high first, then the acknowledge slot
  task automatic xfer(input logic [7:0] tx, input logic ain,
                      output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(ain, ack);
  endtask
endmodule // tra_bus_master
`default_nettype wire

// file: testbench/tra_sensor_test.sv
// Self-checking bench for the temperature result and alert block
`default_nettype none
module tra_sensor_test
  import tra_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  logic        sys_clk;
  logic        link_clk;
  logic        rst_n;
  logic        conv_done;
  logic [11:0] temp_code;
  logic        m_scl;
  logic        m_sda;
  logic        sda_dut;
  logic        sda_oe;
  logic        alert;
  wire         sda_line;
  int          error_cnt;
  int          samples_checked;
  logic [15:0] v;
  logic [7:0]  rx;
  logic        a0;
  logic        a1;
  logic [15:0] rst_tab[4];
  int          degs[2];

  // Wired-and data line with pull-up
  assign sda_line = m_sda & ~(sda_oe & ~sda_dut);

  tra_sensor i_dut (
    .sys_clk_in  (sys_clk),
    .rst_n_in    (rst_n),
    .temp_code_in(temp_code),
    .conv_done_in(conv_done),
    .link_clk_in (link_clk),
    .scl_in      (m_scl),
    .sda_in      (sda_line),
    .sda_out     (sda_dut),
    .sda_oe_out  (sda_oe),
    .alert_out   (alert)
  );

  tra_bus_master i_master (
    .link_clk_in(link_clk),
    .sda_in     (sda_line),
    .scl_out    (m_scl),
    .sda_out    (m_sda)
  );

  // Unrelated clocks, 40 ns and 15 ns
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial begin
    link_clk = 1'b0;
    #3;
    forever #7.5 link_clk = ~link_clk;
  end

  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic ck_alert(input logic e);
    check({15'h0, alert}, {15'h0, e});
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Leaves room for the crossing into the register side
  task automatic settle();
    repeat (12) @(negedge sys_clk);
  endtask

  task automatic conv(input logic [11:0] code);
    @(negedge sys_clk);
    temp_code = code;
    conv_done = 1'b1;
    @(negedge sys_clk);
    conv_done = 1'b0;
    repeat (3) @(negedge sys_clk);
  endtask

  task automatic wr(input logic [1:0] p, input logic [15:0] d, input int n);
    logic [7:0] r;
    logic       ack;
    i_master.start();
    i_master.xfer({DEV_ADDR_DFLT, 1'b0}, 1'b1, r, ack);
    check({15'h0, ack}, 16'h0);
    i_master.xfer({6'h0, p}, 1'b1, r, ack);
    check({15'h0, ack}, 16'h0);
    if (n > 0) begin
      i_master.xfer(d[15:8], 1'b1, r, ack);
      i_master.xfer(d[7:0], 1'b1, r, ack);
    end
    i_master.stop();
    settle();
  endtask

  // Pointer write and stop, new start, two bytes, master nack on the last
  task automatic rd(input logic [1:0] p, output logic [15:0] d);
    logic [7:0] r;
    logic       ack;
    wr(p, 16'h0, 0);
    i_master.start();
    i_master.xfer({DEV_ADDR_DFLT, 1'b1}, 1'b1, r, ack);
    check({15'h0, ack}, 16'h0);
    i_master.xfer(8'hff, 1'b0, d[15:8], ack);
    i_master.xfer(8'hff, 1'b1, d[7:0], ack);
    i_master.stop();
    settle();
  endtask

  // Two raw bytes: alert response, general call, foreign address
  task automatic raw(input logic [7:0] b0, input logic [7:0] b1,
                     output logic [7:0] r, output logic k0,
                     output logic k1);
    i_master.start();
    i_master.xfer(b0, 1'b1, r, k0);
    i_master.xfer(b1, 1'b1, r, k1);
    i_master.stop();
    settle();
  endtask

  // Hang guard
  initial begin
    repeat (100000) @(posedge sys_clk);
    error_cnt++;
    print_verdict();
  end

  initial begin
    error_cnt = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    conv_done = 1'b0;
    temp_code = 12'h000;
    rst_tab = '{TEMP_RST, CFG_RST, TLOW_RST, THIGH_RST};
    degs = '{25, -25};
    repeat (8) @(negedge sys_clk);
    ck_alert(1'b1);
    rst_n = 1'b1;
    repeat (20) @(negedge sys_clk);
    // Result format; writes to the result are ignored
    foreach (degs[i]) begin
      conv(12'(degs[i] * 16));
      wr(PTR_TEMP, 16'h1234, 2);
      rd(PTR_TEMP, v);
      check(v, {12'(degs[i] * 16), TEMP_PAD});
    end
    $display("test 1 done");
    // Register reset values and a foreign address
    for (int p = 1; p < 4; p++) begin
      rd(2'(p), v);
      check(v, rst_tab[p]);
    end
    raw({7'h49, 1'b0}, 8'h00, rx, a0, a1);
    check({15'h0, a0}, 16'h1);
    $display("test 2 done");
    // Comparator, queue of two, broken runs restart the count
    wr(PTR_CFG, 16'h0800, 2);
    conv(12'h500);
    conv(12'h4ff);
    conv(12'h500);
    ck_alert(1'b1);
    conv(12'h520);
    ck_alert(1'b0);
    rd(PTR_TEMP, v);
    ck_alert(1'b0);
    conv(12'h4af);
    conv(12'h4b0);
    conv(12'h4af);
    ck_alert(1'b0);
    conv(12'h4af);
    ck_alert(1'b1);
    $display("test 3 done");
    // Interrupt mode, active high, queue of one
    wr(PTR_CFG, 16'h0600, 2);
    ck_alert(1'b0);
    conv(12'h500);
    ck_alert(1'b1);
    rd(PTR_TLOW, v);
    ck_alert(1'b0);
    conv(12'h500);
    ck_alert(1'b0);
    conv(12'h4af);
    ck_alert(1'b1);
    raw(ALERT_CMD, 8'hff, rx, a0, a1);
    check({8'h0, rx}, {8'h0, DEV_ADDR_DFLT, 1'b0});
    ck_alert(1'b0);
    conv(12'h500);
    ck_alert(1'b1);
    raw(ALERT_CMD, 8'hff, rx, a0, a1);
    check({8'h0, rx}, {8'h0, DEV_ADDR_DFLT, 1'b1});
    conv(12'h4af);
    ck_alert(1'b1);
    wr(PTR_CFG, 16'h0700, 2);
    ck_alert(1'b0);
    $display("test 4 done");
    // General-call reset
    wr(PTR_CFG, 16'h0000, 2);
    conv(12'h500);
    ck_alert(1'b0);
    wr(PTR_THIGH, 16'h3000, 2);
    raw(GC_ADDR, GC_RESET, rx, a0, a1);
    check({14'h0, a0, a1}, 16'h0);
    ck_alert(1'b1);
    rd(PTR_THIGH, v);
    check(v, THIGH_RST);
    // Queue of six: five hot conversions are not enough
    wr(PTR_CFG, 16'h1800, 2);
    repeat (5) conv(12'h500);
    ck_alert(1'b1);
    conv(12'h500);
    ck_alert(1'b0);
    $display("test 5 done");
    print_verdict();
  end
endmodule // tra_sensor_test
`default_nettype wire
